// ===== design/presence_poll_defines.vh
`ifndef PRESENCE_POLL_DEFINES_VH
`define PRESENCE_POLL_DEFINES_VH

// Register byte offsets on the Wishbone slave.
`define OFF_CTRL          8'h00
`define OFF_INTERVAL      8'h04
`define OFF_STATUS        8'h08
`define OFF_IRQ_STATUS    8'h0C
`define OFF_IRQ_MASK      8'h10

// Control register fields.
`define CTRL_CMD_GO       0
`define CTRL_RESET_CMD    1
`define CTRL_BATT_SEL     4

// Status word fields.
`define STAT_PRESENT      0
`define STAT_CMD_PEND     1
`define STAT_BATT_LOW     12
`define STAT_IVAL_LSB     16

// Interrupt status and mask fields.
`define IRQ_ARRIVE        0
`define IRQ_LEAVE         1
`define IRQ_CMD_DONE      2
`define IRQ_BATT_LOW      3
`define IRQ_WIDTH         4

// Reset values.
`define RST_INTERVAL      8'h00
`define RST_IRQ_MASK      4'h0
`define RST_BATT_SEL      1'b0

// Read/write head operation codes.
`define OP_SCAN           2'h0
`define OP_QUERY          2'h1
`define OP_CMD            2'h2

// Poll interval timebase: one tick per 10 ms at a 50 MHz clock.
`define CLK_FREQ_MHZ      50
`define TICK_PERIOD_US    10000
`define TICK_CYCLES       (`TICK_PERIOD_US * `CLK_FREQ_MHZ)

// Tick multipliers selected by the top two bits of the interval code.
`define MULT_10MS         16'h0001
`define MULT_100MS        16'h000A
`define MULT_1S           16'h0064
`define MULT_10S          16'h03E8

`endif

// ===== design/poll_tick_divider.v
`timescale 1ns/10ps
module poll_tick_divider #(
  parameter CYCLES = 500000
) (
  input  wire clk_i,
  input  wire rst_i,
  output reg  tick_o
);

  reg [31:0] count_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= 32'h00000000;
      tick_o  <= 1'b0;
    end else if (count_q == CYCLES - 1) begin
      count_q <= 32'h00000000;
      tick_o  <= 1'b1;
    end else begin
      count_q <= count_q + 32'h00000001;
      tick_o  <= 1'b0;
    end
  end

endmodule

// ===== design/poll_interval_timer.v
`timescale 1ns/10ps
module poll_interval_timer (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        load_i,
  input  wire [15:0] ticks_i,
  input  wire        tick_i,
  output wire        expired_o
);

  reg [15:0] remain_q;
  reg        armed_q;

  // Expired stays high until the next load; a zero load expires at once.
  assign expired_o = armed_q && (remain_q == 16'h0000);

  always @(posedge clk_i) begin
    if (rst_i) begin
      remain_q <= 16'h0000;
      armed_q  <= 1'b0;
    end else if (load_i) begin
      remain_q <= ticks_i;
      armed_q  <= 1'b1;
    end else if (tick_i && remain_q != 16'h0000) begin
      remain_q <= remain_q - 16'h0001;
    end
  end

endmodule

// ===== design/presence_poll_scheduler.v
// Our own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
`include "presence_poll_defines.vh"
module presence_poll_scheduler #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  output wire        irq_o,
  output reg         head_start_o,
  output reg  [1:0]  head_op_o,
  input  wire        head_done_i,
  input  wire        head_found_i,
  input  wire        head_batt_low_i,
  output wire        present_o,
  output wire        batt_low_o
);

  localparam [4:0] S_BOOT  = 5'b00001;
  localparam [4:0] S_SCAN  = 5'b00010;
  localparam [4:0] S_IDLE  = 5'b00100;
  localparam [4:0] S_QUERY = 5'b01000;
  localparam [4:0] S_CMD   = 5'b10000;

  // Interval code: bits 7:6 pick the unit (10 ms, 100 ms, 1 s, 10 s) and
  // bits 5:0 give the count of units.
  function [15:0] decode_interval;
    input [7:0] code;
    reg   [15:0] mult;
    begin
      case (code[7:6])
        2'b00: mult = `MULT_10MS;
        2'b01: mult = `MULT_100MS;
        2'b10: mult = `MULT_1S;
        2'b11: mult = `MULT_10S;
        default: mult = `MULT_10MS;
      endcase
      decode_interval = {10'h000, code[5:0]} * mult;
    end
  endfunction

  reg [4:0]  state_q;
  reg [4:0]  state_d;
  reg        start_d;
  reg [1:0]  op_d;
  reg        present_q;
  reg        present_d;
  reg        op_busy_q;
  reg        pend_q;
  reg        pend_clr;
  reg        timer_load;
  reg        ev_arrive;
  reg        ev_leave;
  reg        ev_cmd_done;
  reg        batt_low_q;
  reg        batt_sel_q;
  reg [7:0]  interval_param_q;
  reg [7:0]  interval_active_q;
  reg [`IRQ_WIDTH-1:0] irq_stat_q;
  reg [`IRQ_WIDTH-1:0] irq_mask_q;
  reg [31:0] rd_data;

  wire       tick;
  wire       expired;
  wire       bus_req;
  wire       wr_en;
  wire       cmd_go_wr;
  wire       reset_cmd_wr;
  wire       batt_low_rise;
  wire       batt_low_next;
  wire [`IRQ_WIDTH-1:0] irq_events;
  wire [`IRQ_WIDTH-1:0] irq_clear;

  poll_tick_divider #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (tick)
  );

  poll_interval_timer u_timer (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .load_i    (timer_load),
    .ticks_i   (decode_interval(interval_active_q)),
    .tick_i    (tick),
    .expired_o (expired)
  );

  // Wishbone classic: ack follows one cycle after the request and drops
  // the cycle after; the write lands on the edge that samples ack.
  assign bus_req      = cyc_i && stb_i;
  assign wr_en        = bus_req && we_i && ack_o;
  assign cmd_go_wr    = wr_en && adr_i == `OFF_CTRL && sel_i[0] &&
                        dat_i[`CTRL_CMD_GO];
  assign reset_cmd_wr = wr_en && adr_i == `OFF_CTRL && sel_i[0] &&
                        dat_i[`CTRL_RESET_CMD];
  assign irq_clear    = (wr_en && adr_i == `OFF_IRQ_STATUS && sel_i[0]) ?
                        dat_i[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}};

  assign present_o  = present_q;
  assign batt_low_o = batt_low_q;
  assign irq_o      = |(irq_stat_q & irq_mask_q);

  always @* begin
    rd_data = 32'h00000000;
    case (adr_i)
      `OFF_CTRL:
        rd_data[`CTRL_BATT_SEL] = batt_sel_q;
      `OFF_INTERVAL:
        rd_data[7:0] = interval_param_q;
      `OFF_STATUS: begin
        rd_data[`STAT_PRESENT]  = present_q;
        rd_data[`STAT_CMD_PEND] = pend_q;
        rd_data[`STAT_BATT_LOW] = batt_low_q;
        rd_data[`STAT_IVAL_LSB+7:`STAT_IVAL_LSB] = interval_active_q;
      end
      `OFF_IRQ_STATUS:
        rd_data[`IRQ_WIDTH-1:0] = irq_stat_q;
      `OFF_IRQ_MASK:
        rd_data[`IRQ_WIDTH-1:0] = irq_mask_q;
      default:
        rd_data = 32'h00000000;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= bus_req && !ack_o;
      if (bus_req && !ack_o) begin
        dat_o <= we_i ? 32'h00000000 : rd_data;
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      batt_sel_q       <= `RST_BATT_SEL;
      interval_param_q <= `RST_INTERVAL;
      irq_mask_q       <= `RST_IRQ_MASK;
    end else if (wr_en) begin
      if (adr_i == `OFF_CTRL && sel_i[0]) begin
        batt_sel_q <= dat_i[`CTRL_BATT_SEL];
      end
      if (adr_i == `OFF_INTERVAL && sel_i[0]) begin
        interval_param_q <= dat_i[7:0];
      end
      if (adr_i == `OFF_IRQ_MASK && sel_i[0]) begin
        irq_mask_q <= dat_i[`IRQ_WIDTH-1:0];
      end
    end
  end

  // The staged code goes live only on the reset command, so an interval
  // change never lands in the middle of a running wait.
  always @(posedge clk_i) begin
    if (rst_i) begin
      interval_active_q <= `RST_INTERVAL;
    end else if (reset_cmd_wr) begin
      interval_active_q <= interval_param_q;
    end
  end

  always @* begin
    state_d     = state_q;
    start_d     = 1'b0;
    op_d        = head_op_o;
    present_d   = present_q;
    pend_clr    = 1'b0;
    timer_load  = 1'b0;
    ev_arrive   = 1'b0;
    ev_leave    = 1'b0;
    ev_cmd_done = 1'b0;
    case (state_q)
      S_BOOT: begin
        // Wait out an operation still running on the head, so its late
        // answer is never taken as the answer to the new scan.
        if (!op_busy_q || head_done_i) begin
          state_d = S_SCAN;
          start_d = 1'b1;
          op_d    = `OP_SCAN;
        end
      end
      S_SCAN: begin
        if (head_done_i) begin
          if (head_found_i) begin
            present_d = 1'b1;
            ev_arrive = 1'b1;
            if (pend_q) begin
              state_d = S_CMD;
              start_d = 1'b1;
              op_d    = `OP_CMD;
            end else begin
              state_d    = S_IDLE;
              timer_load = 1'b1;
            end
          end else begin
            start_d = 1'b1;
            op_d    = `OP_SCAN;
          end
        end
      end
      S_IDLE: begin
        if (pend_q) begin
          state_d = S_CMD;
          start_d = 1'b1;
          op_d    = `OP_CMD;
        end else if (expired) begin
          state_d = S_QUERY;
          start_d = 1'b1;
          op_d    = `OP_QUERY;
        end
      end
      S_QUERY: begin
        if (head_done_i) begin
          if (head_found_i) begin
            // Any tag answering keeps presence, so a swap stays silent.
            state_d    = S_IDLE;
            timer_load = 1'b1;
          end else begin
            state_d   = S_SCAN;
            start_d   = 1'b1;
            op_d      = `OP_SCAN;
            present_d = 1'b0;
            ev_leave  = 1'b1;
          end
        end
      end
      S_CMD: begin
        if (head_done_i) begin
          ev_cmd_done = 1'b1;
          pend_clr    = 1'b1;
          if (head_found_i) begin
            state_d    = S_IDLE;
            timer_load = 1'b1;
          end else begin
            state_d   = S_SCAN;
            start_d   = 1'b1;
            op_d      = `OP_SCAN;
            present_d = 1'b0;
            ev_leave  = 1'b1;
          end
        end
      end
      default: begin
        state_d = S_BOOT;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q      <= S_BOOT;
      head_start_o <= 1'b0;
      head_op_o    <= `OP_SCAN;
      present_q    <= 1'b0;
    end else if (reset_cmd_wr) begin
      state_q      <= S_BOOT;
      head_start_o <= 1'b0;
      head_op_o    <= `OP_SCAN;
      present_q    <= 1'b0;
    end else begin
      state_q      <= state_d;
      head_start_o <= start_d;
      head_op_o    <= op_d;
      present_q    <= present_d;
    end
  end

  // Tracks an operation in flight on the head; the reset command keeps it.
  always @(posedge clk_i) begin
    if (rst_i) begin
      op_busy_q <= 1'b0;
    end else if (head_start_o) begin
      op_busy_q <= 1'b1;
    end else if (head_done_i) begin
      op_busy_q <= 1'b0;
    end
  end

  // A command written in the cycle it completes stays pending.
  always @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= (pend_q && !pend_clr && !reset_cmd_wr) || cmd_go_wr;
    end
  end

  assign batt_low_next = batt_sel_q &&
                         (head_done_i && head_found_i ?
                          head_batt_low_i : batt_low_q);
  assign batt_low_rise = batt_low_next && !batt_low_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      batt_low_q <= 1'b0;
    end else begin
      batt_low_q <= batt_low_next;
    end
  end

  assign irq_events = {batt_low_rise, ev_cmd_done, ev_leave, ev_arrive};

  // Sticky bits, cleared by writing one; a new event beats the clear.
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= {`IRQ_WIDTH{1'b0}};
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clear) | irq_events;
    end
  end

endmodule

// ===== testbench/presence_poll_assertions.sv
`timescale 1ns/10ps
module presence_poll_assertions (
  input wire       clk_i,
  input wire       rst_i,
  input wire       cyc_i,
  input wire       stb_i,
  input wire       ack_o,
  input wire       head_start_o,
  input wire [1:0] head_op_o,
  input wire       head_done_i,
  input wire       head_found_i,
  input wire       head_batt_low_i,
  input wire       present_o,
  input wire       batt_low_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_scan;
    head_start_o && head_op_o == 2'h0;
  endsequence
  sequence s_miss;
    head_done_i && !head_found_i;
  endsequence
  chk_ack_answer: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o) else $error("bad ack");
  chk_start_pulse: assert property (
    head_start_o |=> !head_start_o) else $error("start too long");
  chk_scan_retry: assert property (
    (!present_o && head_op_o == 2'h0) ##0 s_miss |-> ##[1:3] s_scan)
    else $error("scan not resumed");
  chk_found_present: assert property (
    head_done_i && head_found_i && head_op_o == 2'h0 |=> present_o)
    else $error("tag not marked present");
  chk_leave_rescan: assert property (
    present_o ##0 s_miss |=> !present_o ##[0:1] s_scan)
    else $error("leave not handled");
  chk_no_scan: assert property (
    present_o && head_start_o |-> head_op_o != 2'h0)
    else $error("scan while present");
  chk_swap_silent: assert property (
    present_o && head_done_i && head_found_i |=> present_o)
    else $error("presence dropped");
  chk_batt_clear: assert property (
    head_done_i && head_found_i && !head_batt_low_i |=> !batt_low_o)
    else $error("battery flag stuck");
endmodule

// ===== testbench/tag_head_model.sv
`timescale 1ns/10ps
module tag_head_model (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       start_i,
  input  wire       tag_i,
  input  wire       batt_i,
  input  wire [3:0] lat_i,
  output reg        done_o,
  output reg        found_o,
  output reg        batt_low_o
);
  // Cycles without a start after which the tag drops to standby.
  localparam [7:0] IDLE_LIMIT = 8'h10;
  reg [3:0] cnt_q;
  reg       busy_q;
  reg [7:0] idle_q;
  reg       woke_q;
  // A sleeping tag answers only if tag_i is already high when the start comes.
  always @(posedge clk_i) begin
    if (rst_i || start_i) begin
      idle_q <= 8'h00;
    end else if (idle_q != IDLE_LIMIT) begin
      idle_q <= idle_q + 8'h01;
    end
  end
  // Answer lines toggle outside the done pulse so stale values never pass.
  always @(posedge clk_i) begin
    done_o <= 1'h0;
    found_o <= ~found_o;
    batt_low_o <= ~batt_low_o;
    if (rst_i) begin
      busy_q <= 1'h0;
      found_o <= 1'h0;
      batt_low_o <= 1'h0;
    end else if (start_i) begin
      busy_q <= 1'h1;
      cnt_q <= lat_i;
      woke_q <= idle_q != IDLE_LIMIT || tag_i;
    end else if (busy_q && cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else if (busy_q) begin
      busy_q <= 1'h0;
      done_o <= 1'h1;
      found_o <= tag_i & woke_q;
      batt_low_o <= tag_i & woke_q & batt_i;
    end
  end
endmodule

// ===== testbench/presence_poll_scheduler_tb.sv
`timescale 1ns/10ps
`include "presence_poll_defines.vh"
module presence_poll_scheduler_tb;
  reg         clk_i, rst_i, cyc_i, stb_i, we_i, tag, batt;
  reg  [3:0]  sel_i, lat;
  reg  [7:0]  adr_i;
  reg  [31:0] dat_i, q;
  wire [31:0] dat_o;
  wire [1:0]  head_op_o;
  wire        ack_o, irq_o, head_start_o, head_done_i, head_found_i;
  wire        head_batt_low_i, present_o, batt_low_o;
  integer     compares, miscompares, ticks, n_scan, n_query, n_cmd, i, k;
  presence_poll_scheduler #(.TICK_CYCLES(4)) u_presence_poll_scheduler (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
    .head_start_o(head_start_o), .head_op_o(head_op_o),
    .head_done_i(head_done_i), .head_found_i(head_found_i),
    .head_batt_low_i(head_batt_low_i), .present_o(present_o),
    .batt_low_o(batt_low_o));
  tag_head_model u_tag_head_model (
    .clk_i(clk_i), .rst_i(rst_i), .start_i(head_start_o), .tag_i(tag),
    .batt_i(batt), .lat_i(lat), .done_o(head_done_i),
    .found_o(head_found_i), .batt_low_o(head_batt_low_i));
  initial begin
    clk_i = 1'h0;
    forever #10 clk_i = ~clk_i;
  end
  task print_verdict;
    begin
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  always @(posedge clk_i) begin
    ticks <= ticks + 1;
    if (head_start_o === 1'h1) begin
      n_scan <= n_scan + (head_op_o === `OP_SCAN);
      n_query <= n_query + (head_op_o === `OP_QUERY);
      n_cmd <= n_cmd + (head_op_o === `OP_CMD);
    end
    if (ticks == 5000) begin
      miscompares = miscompares + 1;
      print_verdict;
    end
  end
  task ck(input [31:0] g, input [31:0] e);
    begin
      compares = compares + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  task wb(input [7:0] a, input w, input [31:0] d);
    begin
      @(posedge clk_i);
      cyc_i <= 1'h1;
      stb_i <= 1'h1;
      we_i <= w;
      sel_i <= 4'hF;
      adr_i <= a;
      dat_i <= d;
      @(posedge clk_i);
      while (ack_o !== 1'h1) @(posedge clk_i);
      q = dat_o;
      cyc_i <= 1'h0;
      stb_i <= 1'h0;
    end
  endtask
  task t_reset_vals;
    begin
      for (i = 0; i < 6; i = i + 1) begin
        wb(8'(4 * i), 1'h0, 32'h0);
        ck(q & (i != 0 ? 32'hFFFFFFFF : 32'h10), 32'h0);
      end
      wb(8'h14, 1'h1, 32'hFFFFFFFF);
      wb(8'h14, 1'h0, 32'h0);
      ck(q, 32'h0);
    end
  endtask
  task t_scan;
    begin
      lat <= 4'h0;
      k = n_scan;
      wt(40);
      ck(n_scan - k >= 8, 32'h1);
      ck(present_o, 32'h0);
    end
  endtask
  task t_arrive;
    begin
      lat <= 4'h1;
      wb(`OFF_INTERVAL, 1'h1, 32'h05);
      wb(`OFF_CTRL, 1'h1, 32'h12);
      wb(`OFF_STATUS, 1'h0, 32'h0);
      ck(q[23:16], 32'h05);
      wb(`OFF_IRQ_MASK, 1'h1, 32'h1);
      tag <= 1'h1;
      for (i = 0; i < 60 && present_o !== 1'h1; i = i + 1) wt(1);
      ck(irq_o, 32'h1);
      wb(`OFF_IRQ_STATUS, 1'h1, 32'h1);
      wt(1);
      ck(irq_o, 32'h0);
      k = n_query;
      i = n_scan;
      wt(200);
      ck(n_scan - i, 32'h0);
      ck(n_query - k >= 6 && n_query - k <= 10, 32'h1);
    end
  endtask
  task t_cmd;
    begin
      k = n_cmd;
      wb(`OFF_CTRL, 1'h1, 32'h11);
      // A query already on the head finishes first: up to seven cycles.
      for (i = 0; i < 10 && n_cmd == k; i = i + 1) wt(1);
      ck(n_cmd - k, 32'h1);
    end
  endtask
  task t_batt;
    begin
      batt <= 1'h1;
      wt(40);
      ck(batt_low_o, 32'h1);
      wb(`OFF_STATUS, 1'h0, 32'h0);
      ck(q[12], 32'h1);
      batt <= 1'h0;
      wt(40);
      ck(batt_low_o, 32'h0);
    end
  endtask
  task t_swap;
    begin
      wb(`OFF_IRQ_STATUS, 1'h1, 32'hF);
      k = n_query;
      for (i = 0; i < 60 && n_query == k; i = i + 1) wt(1);
      wt(4);
      tag <= 1'h0;
      wt(5);
      tag <= 1'h1;
      wt(40);
      ck(present_o, 32'h1);
      wb(`OFF_IRQ_STATUS, 1'h0, 32'h0);
      ck(q[1], 32'h0);
    end
  endtask
  task t_leave;
    begin
      wb(`OFF_IRQ_MASK, 1'h1, 32'h2);
      tag <= 1'h0;
      for (i = 0; i < 60 && present_o !== 1'h0; i = i + 1) wt(1);
      k = n_scan;
      wt(4);
      ck(n_scan > k, 32'h1);
      ck(irq_o, 32'h1);
      wb(`OFF_IRQ_STATUS, 1'h1, 32'h2);
      wt(1);
      ck(irq_o, 32'h0);
    end
  endtask
  initial begin
    compares = 0; miscompares = 0; ticks = 0;
    n_scan = 0; n_query = 0; n_cmd = 0;
    rst_i = 1'h1; cyc_i = 1'h0; stb_i = 1'h0; we_i = 1'h0;
    adr_i = 8'h00; dat_i = 32'h0; sel_i = 4'hF;
    tag = 1'h0; batt = 1'h0; lat = 4'h1;
    wt(6);
    rst_i <= 1'h0;
    t_reset_vals;
    t_scan;
    t_arrive;
    t_cmd;
    t_batt;
    t_swap;
    t_leave;
    print_verdict;
  end
endmodule
bind presence_poll_scheduler presence_poll_assertions u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .head_start_o(head_start_o), .head_op_o(head_op_o),
  .head_done_i(head_done_i), .head_found_i(head_found_i),
  .head_batt_low_i(head_batt_low_i), .present_o(present_o),
  .batt_low_o(batt_low_o));
